/* File: rtl/sbc_pkg.sv */
// Constants, register map and carrier types for the synthesizer buffer and calibration registers.
// Assumes an APB master on pclk and a reference clock sampled as a plain pin.
package sbc_pkg;

  // Register indices as printed; byte address is four times the index
  localparam logic [7:0] IDX_SWING   = 8'h18;
  localparam logic [7:0] IDX_CURRENT = 8'h19;
  localparam logic [7:0] IDX_BW      = 8'h1a;
  localparam logic [7:0] IDX_CAL     = 8'h1b;
  localparam logic [7:0] IDX_STATUS  = 8'h30;
  localparam logic [9:0] ADDR_SWING   = {IDX_SWING, 2'b00};
  localparam logic [9:0] ADDR_CURRENT = {IDX_CURRENT, 2'b00};
  localparam logic [9:0] ADDR_BW      = {IDX_BW, 2'b00};
  localparam logic [9:0] ADDR_CAL     = {IDX_CAL, 2'b00};
  localparam logic [9:0] ADDR_STATUS  = {IDX_STATUS, 2'b00};

  // Reset values
  localparam logic [1:0] RST_PRE_SWING   = 2'h3;
  localparam logic [2:0] RST_RX_SWING    = 3'h4;
  localparam logic [2:0] RST_TX_SWING    = 3'h1;
  localparam logic [1:0] RST_PRE_CURRENT = 2'h1;
  localparam logic [2:0] RST_RX_CURRENT  = 3'h4;
  localparam logic [2:0] RST_TX_CURRENT  = 3'h5;
  localparam logic [7:0] RST_BW          = 8'h86;
  localparam logic [1:0] RST_CAL_WAIT    = 2'h0;
  localparam logic [2:0] RST_CAL_ITER    = 3'h5;

  // Calibration lengths in reference-clock periods
  localparam int CAL_WAIT_PERIODS0 = 90000;
  localparam int CAL_WAIT_PERIODS1 = 110000;
  localparam int CAL_WAIT_PERIODS2 = 130000;
  localparam int CAL_WAIT_PERIODS3 = 200000;
  localparam int CAL_CNT_W         = 18;

  typedef struct packed {
    logic [1:0] pre;
    logic [2:0] rx;
    logic [2:0] tx;
  } sbc_buffer_type;

  // Control layout: start[7], dual[6], wait[5:4], reserved[3], iteration[2:0]
  typedef struct packed {
    logic       start;
    logic       dual;
    logic [1:0] wait_sel;
    logic       rsvd;
    logic [2:0] iter;
  } sbc_cal_ctrl_type;

  typedef enum logic [1:0] {
    CAL_IDLE,
    CAL_RUN,
    CAL_STORE
  } sbc_cal_state_type;

endpackage

/* File: rtl/sbc_regs.sv */
// Synthesizer buffer, loop bandwidth and calibration registers with an APB slave and calibration sequencer.
// Assumes APB on pclk, ref_clk_in as an asynchronous pin and freq_select from logic on pclk.
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
module sbc_regs
  import sbc_pkg::*;
#(
  parameter int CAL_PERIODS0 = CAL_WAIT_PERIODS0,
  parameter int CAL_PERIODS1 = CAL_WAIT_PERIODS1,
  parameter int CAL_PERIODS2 = CAL_WAIT_PERIODS2,
  parameter int CAL_PERIODS3 = CAL_WAIT_PERIODS3
) (
  // Clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // APB slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [9:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic                      pready,
  output logic [31:0]               prdata,
  output logic                      pslverr,
  // Synthesizer side
  input  wire logic                 ref_clk_in,
  input  wire logic                 freq_select,
  output sbc_buffer_type            lo_buffer_swing_ctrl,
  output sbc_buffer_type            lo_buffer_current_ctrl,
  output logic [7:0]                loop_bandwidth_scale,
  output logic [3:0]                calibration_dac_seed,
  output logic                      cal_busy,
  output logic                      store_set_a,
  output logic                      store_set_b
);

  sbc_cal_ctrl_type       cal_ctrl;
  sbc_cal_ctrl_type       next_cal_ctrl;
  sbc_buffer_type         next_swing;
  sbc_buffer_type         next_current;
  logic [7:0]             next_bw;
  logic                   next_pready;
  logic [31:0]            next_prdata;
  logic                   next_pslverr;
  logic                   wr_en;
  logic                   addr_hit;
  logic                   cal_start_req;
  sbc_cal_ctrl_type       wr_ctrl;

  // APB: one wait state, read data and answer registered
  always_comb begin
    addr_hit = (paddr == ADDR_SWING) || (paddr == ADDR_CURRENT) || (paddr == ADDR_BW)
            || (paddr == ADDR_CAL) || (paddr == ADDR_STATUS);
    wr_en        = psel && penable && pready && pwrite && addr_hit;
    next_pready  = psel && penable && !pready;
    next_pslverr = psel && penable && !pready && !addr_hit;
    next_prdata  = 32'h0000_0000;
    if (psel && penable && !pready && !pwrite) begin
      unique case (paddr)
        ADDR_SWING:   next_prdata = {24'h00_0000, lo_buffer_swing_ctrl};
        ADDR_CURRENT: next_prdata = {24'h00_0000, lo_buffer_current_ctrl};
        ADDR_BW:      next_prdata = {24'h00_0000, loop_bandwidth_scale};
        ADDR_CAL:     next_prdata = {24'h00_0000, cal_ctrl};
        ADDR_STATUS:  next_prdata = {31'h0000_0000, cal_busy};
        default:      next_prdata = 32'h0000_0000;
      endcase
    end
  end

  // Register writes
  always_comb begin
    wr_ctrl       = pwdata[7:0];
    next_swing    = lo_buffer_swing_ctrl;
    next_current  = lo_buffer_current_ctrl;
    next_bw       = loop_bandwidth_scale;
    next_cal_ctrl = cal_ctrl;
    cal_start_req = 1'b0;
    if (wr_en && paddr == ADDR_SWING) begin
      next_swing = pwdata[7:0];
    end
    if (wr_en && paddr == ADDR_CURRENT) begin
      next_current = pwdata[7:0];
    end
    if (wr_en && paddr == ADDR_BW) begin
      next_bw = pwdata[7:0];
    end
    if (wr_en && paddr == ADDR_CAL) begin
      next_cal_ctrl      = wr_ctrl;
      next_cal_ctrl.rsvd = 1'b0;
      cal_start_req = wr_ctrl.start && !cal_ctrl.start;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lo_buffer_swing_ctrl   <= '{pre: RST_PRE_SWING, rx: RST_RX_SWING, tx: RST_TX_SWING};
      lo_buffer_current_ctrl <= '{pre: RST_PRE_CURRENT, rx: RST_RX_CURRENT, tx: RST_TX_CURRENT};
      loop_bandwidth_scale   <= RST_BW;
      cal_ctrl               <= '{start: 1'b0, dual: 1'b0, wait_sel: RST_CAL_WAIT, rsvd: 1'b0,
                                  iter: RST_CAL_ITER};
      pready                 <= 1'b0;
      pslverr                <= 1'b0;
      prdata                 <= 32'h0000_0000;
    end else begin
      lo_buffer_swing_ctrl   <= next_swing;
      lo_buffer_current_ctrl <= next_current;
      loop_bandwidth_scale   <= next_bw;
      cal_ctrl               <= next_cal_ctrl;
      pready                 <= next_pready;
      pslverr                <= next_pslverr;
      prdata                 <= next_prdata;
    end
  end

  // Reference clock synchroniser and edge detect
  logic ref_meta;
  logic ref_sync;
  logic ref_prev;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_meta <= 1'b0;
      ref_sync <= 1'b0;
      ref_prev <= 1'b0;
    end else begin
      ref_meta <= ref_clk_in;
      ref_sync <= ref_meta;
      ref_prev <= ref_sync;
    end
  end

  // Calibration sequencer
  sbc_cal_state_type       cal_state;
  sbc_cal_state_type       next_cal_state;
  logic [CAL_CNT_W-1:0]    cal_cnt;
  logic [CAL_CNT_W-1:0]    next_cal_cnt;
  logic [CAL_CNT_W-1:0]    cal_limit;
  logic [CAL_CNT_W-1:0]    next_cal_limit;
  logic                    cal_dual;
  logic                    next_cal_dual;
  logic                    cal_fsel;
  logic                    next_cal_fsel;
  logic [3:0]              next_seed;
  logic                    next_busy;
  logic                    next_store_a;
  logic                    next_store_b;
  logic                    ref_tick;

  always_comb begin
    ref_tick       = ref_sync && !ref_prev;
    next_cal_state = cal_state;
    next_cal_cnt   = cal_cnt;
    next_cal_limit = cal_limit;
    next_cal_dual  = cal_dual;
    next_cal_fsel  = cal_fsel;
    next_seed      = calibration_dac_seed;
    next_store_a   = 1'b0;
    next_store_b   = 1'b0;
    unique case (cal_state)
      CAL_IDLE: begin
        if (cal_start_req) begin
          next_cal_state = CAL_RUN;
          next_cal_cnt   = '0;
          next_cal_dual  = wr_ctrl.dual;
          next_cal_fsel  = freq_select;
          next_seed      = {1'b0, wr_ctrl.iter} + 4'h1;
          unique case (wr_ctrl.wait_sel)
            2'h0: next_cal_limit = CAL_CNT_W'(CAL_PERIODS0);
            2'h1: next_cal_limit = CAL_CNT_W'(CAL_PERIODS1);
            2'h2: next_cal_limit = CAL_CNT_W'(CAL_PERIODS2);
            2'h3: next_cal_limit = CAL_CNT_W'(CAL_PERIODS3);
          endcase
        end
      end
      CAL_RUN: begin
        if (ref_tick) begin
          next_cal_cnt = cal_cnt + CAL_CNT_W'(1);
          if (cal_cnt + CAL_CNT_W'(1) >= cal_limit) begin
            next_cal_state = CAL_STORE;
          end
        end
      end
      CAL_STORE: begin
        // store to both or selected set
        next_store_a   = cal_dual || !cal_fsel;
        next_store_b   = cal_dual || cal_fsel;
        next_cal_state = CAL_IDLE;
      end
      // Spare state code falls back to idle
      default: next_cal_state = CAL_IDLE;
    endcase
    next_busy = (next_cal_state != CAL_IDLE);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal_state            <= CAL_IDLE;
      cal_cnt              <= '0;
      cal_limit            <= '0;
      cal_dual             <= 1'b0;
      cal_fsel             <= 1'b0;
      calibration_dac_seed <= {1'b0, RST_CAL_ITER} + 4'h1;
      cal_busy             <= 1'b0;
      store_set_a          <= 1'b0;
      store_set_b          <= 1'b0;
    end else begin
      cal_state            <= next_cal_state;
      cal_cnt              <= next_cal_cnt;
      cal_limit            <= next_cal_limit;
      cal_dual             <= next_cal_dual;
      cal_fsel             <= next_cal_fsel;
      calibration_dac_seed <= next_seed;
      cal_busy             <= next_busy;
      store_set_a          <= next_store_a;
      store_set_b          <= next_store_b;
    end
  end

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_cal_write_rise;
    psel && penable && pready && pwrite && paddr == ADDR_CAL && pwdata[7] && !cal_ctrl.start
      && cal_state == CAL_IDLE;
  endsequence

  sequence s_apb_write;
    psel && penable && pready && pwrite;
  endsequence

  // Store pulse with busy low, then both pulses low again
  sequence s_store_end;
    !cal_busy && (store_set_a || store_set_b) ##1 !store_set_a && !store_set_b;
  endsequence

  a_pre_swing_reset: assert property ($rose(presetn) |-> lo_buffer_swing_ctrl.pre == 2'h3)
    else $error("prescaler swing reset wrong");
  a_rx_swing_reset: assert property ($rose(presetn) |-> lo_buffer_swing_ctrl.rx == 3'h4)
    else $error("rx swing reset wrong");
  a_tx_swing_reset: assert property ($rose(presetn) |-> lo_buffer_swing_ctrl.tx == 3'h1)
    else $error("tx swing reset wrong");
  a_pre_cur_reset: assert property ($rose(presetn) |-> lo_buffer_current_ctrl.pre == 2'h1)
    else $error("prescaler current reset wrong");
  a_rx_cur_reset: assert property ($rose(presetn) |-> lo_buffer_current_ctrl.rx == 3'h4)
    else $error("rx current reset wrong");
  a_tx_cur_reset: assert property ($rose(presetn) |-> lo_buffer_current_ctrl.tx == 3'h5)
    else $error("tx current reset wrong");
  a_bw_reset_value: assert property ($rose(presetn) |-> loop_bandwidth_scale == 8'h86)
    else $error("bandwidth reset wrong");
  a_cal_start_rise: assert property (s_cal_write_rise |=> cal_busy ##1 cal_state == CAL_RUN)
    else $error("calibration did not start");
  a_busy_needs_rise: assert property ($rose(cal_busy) |-> $past(cal_state) == CAL_IDLE
    && $past(psel && penable && pready && pwrite && paddr == ADDR_CAL && pwdata[7] && !cal_ctrl.start))
    else $error("calibration began without a start rise");
  a_dual_store_sets: assert property ($rose(store_set_a || store_set_b)
    |-> store_set_a == ($past(cal_dual) || !$past(cal_fsel))
    && store_set_b == ($past(cal_dual) || $past(cal_fsel)))
    else $error("wrong frequency set stored");
  a_wait_code_zero: assert property ((s_cal_write_rise and (pwdata[5:4] == 2'h0))
    |=> cal_limit == CAL_CNT_W'(CAL_PERIODS0))
    else $error("wait length zero not selected");
  a_wait_code_one: assert property ((s_cal_write_rise and (pwdata[5:4] == 2'h1))
    |=> cal_limit == CAL_CNT_W'(CAL_PERIODS1))
    else $error("wait length one not selected");
  a_wait_code_two: assert property ((s_cal_write_rise and (pwdata[5:4] == 2'h2))
    |=> cal_limit == CAL_CNT_W'(CAL_PERIODS2))
    else $error("wait length two not selected");
  a_wait_length_sel: assert property ((s_cal_write_rise and (pwdata[5:4] == 2'h3))
    |=> cal_limit == CAL_CNT_W'(CAL_PERIODS3))
    else $error("wait length not selected");
  a_dac_seed_value: assert property (s_cal_write_rise
    |=> calibration_dac_seed == {1'b0, $past(pwdata[2:0])} + 4'h1)
    else $error("dac seed not code plus one");
  a_seed_held_busy: assert property (cal_busy && $past(cal_busy) |-> $stable(calibration_dac_seed))
    else $error("dac seed changed while calibrating");

  // Register writes land one edge after the access
  a_swing_write_land: assert property ((s_apb_write and (paddr == ADDR_SWING))
    |=> lo_buffer_swing_ctrl == $past(pwdata[7:0]))
    else $error("swing write lost");
  a_cur_write_land: assert property ((s_apb_write and (paddr == ADDR_CURRENT))
    |=> lo_buffer_current_ctrl == $past(pwdata[7:0]))
    else $error("current write lost");
  a_bw_write_land: assert property ((s_apb_write and (paddr == ADDR_BW))
    |=> loop_bandwidth_scale == $past(pwdata[7:0]))
    else $error("bandwidth write lost");
  a_ctrl_write_land: assert property ((s_apb_write and (paddr == ADDR_CAL))
    |=> cal_ctrl == {$past(pwdata[7:4]), 1'b0, $past(pwdata[2:0])})
    else $error("control write lost");
  a_ctrl_rsvd_zero: assert property (cal_ctrl.rsvd == 1'b0)
    else $error("reserved control bit set");

  // Calibration sequencing
  a_cal_count_ends: assert property (cal_state == CAL_RUN |-> cal_cnt < cal_limit)
    else $error("calibration overran its wait");
  a_cal_store_count: assert property (cal_state == CAL_STORE |-> cal_cnt == cal_limit)
    else $error("calibration ended early");
  a_store_end_pulse: assert property (cal_state == CAL_STORE |=> s_store_end)
    else $error("store pulse wrong at calibration end");

endmodule

/* File: tb/sbc_regs_tb.sv */
// Self-checking bench for the synthesizer buffer and calibration registers.
// Drives APB, freq_select and a free-running reference clock pin itself.
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
module sbc_regs_tb;
  import sbc_pkg::*;
  localparam int NP[4] = '{4, 5, 6, 8};
  logic           pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic           ref_clk_in = 0, freq_select = 0;
  logic [9:0]     paddr = '0;
  logic [31:0]    pwdata = '0;
  logic [31:0]    prdata;
  logic           pready, pslverr, cal_busy, store_set_a, store_set_b;
  sbc_buffer_type swing, curr;
  logic [7:0]     bw;
  logic [3:0]     seed;
  int             n_errors = 0, checks_done = 0, n_wait = 0, n_ref = 0;
  logic [33:0]    q_rd[$];
  logic [1:0]     q_st[$];
  logic [33:0]    e;
  logic [1:0]     es;

  sbc_regs #(.CAL_PERIODS0(4), .CAL_PERIODS1(5), .CAL_PERIODS2(6), .CAL_PERIODS3(8)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .ref_clk_in(ref_clk_in), .freq_select(freq_select), .lo_buffer_swing_ctrl(swing),
    .lo_buffer_current_ctrl(curr), .loop_bandwidth_scale(bw), .calibration_dac_seed(seed),
    .cal_busy(cal_busy), .store_set_a(store_set_a), .store_set_b(store_set_b));

  initial forever #5 pclk = ~pclk;
  // Reference clock unrelated in phase to pclk
  initial forever #17 ref_clk_in = ~ref_clk_in;
  always @(posedge ref_clk_in) if (cal_busy === 1'b1) n_ref++;

  // Result watcher: APB answers and store pulses against queued notes
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      e = q_rd.size() ? q_rd.pop_front() : 34'h0;
      `CHK("pslverr", e[32], pslverr)
      if (e[33]) `CHK("prdata", e[31:0], prdata)
    end
    if (store_set_a === 1'b1 || store_set_b === 1'b1) begin
      es = q_st.size() ? q_st.pop_front() : 2'b00;
      `CHK("store", es, {store_set_a, store_set_b})
      `CHK("cal len", 1'b1, n_ref >= NP[n_wait] - 1 && n_ref <= NP[n_wait] + 1)
    end
  end

  task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d, input logic [33:0] x);
    @(posedge pclk);
    q_rd.push_back(x);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d}, 34'h0);
  endtask

  task automatic rd(input logic [9:0] a, input logic [31:0] d);
    apb(1'b0, a, 32'h0, {2'b10, d});
  endtask

  task automatic rst();
    presetn <= 0;
    repeat (16) @(posedge pclk);
    presetn <= 1;
  endtask

  task automatic cal(input int w, input logic du, input logic [2:0] it, input logic fs);
    int n;
    n_wait = w;
    q_st.push_back(du ? 2'b11 : (fs ? 2'b01 : 2'b10));
    freq_select <= fs;
    wr(ADDR_CAL, {1'b0, du, w[1:0], 1'b0, it});
    wr(ADDR_CAL, {1'b1, du, w[1:0], 1'b0, it});
    n_ref = 0;
    n = 0;
    while (cal_busy !== 1'b1 && n < 4) begin @(posedge pclk); n++; end
    `CHK("busy", 1'b1, cal_busy)
    `CHK("seed", {1'b0, it} + 4'h1, seed)
    if (w == 3) begin
      rd(ADDR_STATUS, 32'h1);
      wr(ADDR_CAL, {1'b0, ~du, 2'h3, 1'b0, it});
      wr(ADDR_CAL, {1'b1, ~du, 2'h3, 1'b0, it});
    end
    n = 0;
    while (cal_busy !== 1'b0 && n < 1000) begin @(posedge pclk); n++; end
    repeat (3) @(posedge pclk);
    `CHK("store left", 0, q_st.size())
  endtask

  task automatic complete_run();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    #300us;
    n_errors++;
    complete_run();
  end

  initial begin
    logic [31:0] v;
    void'($urandom(32'h1476fac1));
    rst();
    `CHK("swing rst", {2'h3, 3'h4, 3'h1}, swing)
    `CHK("curr rst", {2'h1, 3'h4, 3'h5}, curr)
    `CHK("seed rst", 4'h6, seed)
    rd(ADDR_SWING, 32'he1);
    rd(ADDR_CURRENT, 32'h65);
    rd(ADDR_BW, 32'h86);
    rd(ADDR_CAL, 32'h05);
    repeat (4) begin
      v = $urandom;
      wr(ADDR_SWING, v[7:0]);
      wr(ADDR_CURRENT, v[15:8]);
      wr(ADDR_BW, v[23:16]);
      rd(ADDR_SWING, {24'h0, v[7:0]});
      rd(ADDR_CURRENT, {24'h0, v[15:8]});
      rd(ADDR_BW, {24'h0, v[23:16]});
      `CHK("swing out", v[7:0], swing)
      `CHK("curr out", v[15:8], curr)
      `CHK("bw out", v[23:16], bw)
    end
    // Unmapped place: write ignored, read zero, error flagged
    apb(1'b1, 10'h3fc, 32'hff, {2'b01, 32'h0});
    apb(1'b0, 10'h3fc, 32'h0, {2'b11, 32'h0});
    rd(ADDR_SWING, {24'h0, v[7:0]});
    wr(ADDR_CAL, 8'h7a);
    rd(ADDR_CAL, 32'h72);
    for (int k = 0; k < 8; k++) cal(k % 4, k >= 4, k[2:0], k[0]);
    wr(ADDR_CAL, 8'hb3);
    repeat (5) @(posedge pclk);
    `CHK("no restart", 1'b0, cal_busy)
    rst();
    rd(ADDR_BW, 32'h86);
    `CHK("seed rst2", 4'h6, seed)
    repeat (2) @(posedge pclk);
    complete_run();
  end
endmodule
